// ### hdl/self_refresh_pkg.sv
// Purpose: shared constants and types for the self refresh sequencer
// Assumes: 10 MHz core clock, register port with 8-bit byte addresses
// Notes:   times are kept in ns and converted to core cycles here
package self_refresh_pkg;

    // ==========================================================
    // clock and time conversion
    localparam int CLK_PERIOD_NS = 100;

    // least times round up to whole cycles, never below one
    function automatic int ceil_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // ==========================================================
    // timing
    localparam int REFRESH_CYCLE_NS   = 160;
    localparam int EXIT_MARGIN_NS     = 10;
    localparam int EXIT_DELAY_NS      = REFRESH_CYCLE_NS + EXIT_MARGIN_NS;
    localparam int EXIT_FAST_NS       = 100;
    localparam int EXIT_ABORT_NS      = 100;
    localparam int EXIT_LOCKED_NS     = 614400;
    localparam int CAL_DELAY_NS       = 2400;
    localparam int REFRESH_PERIOD_NS  = 7800;

    localparam int REFRESH_CYCLES     = ceil_cycles(REFRESH_CYCLE_NS);
    localparam int EXIT_CYCLES        = ceil_cycles(EXIT_DELAY_NS);
    localparam int EXIT_FAST_CYCLES   = ceil_cycles(EXIT_FAST_NS);
    localparam int EXIT_ABORT_CYCLES  = ceil_cycles(EXIT_ABORT_NS);
    localparam int EXIT_LOCKED_CYCLES = ceil_cycles(EXIT_LOCKED_NS);
    localparam int CAL_CYCLES         = ceil_cycles(CAL_DELAY_NS);
    localparam int PERIOD_CYCLES      = ceil_cycles(REFRESH_PERIOD_NS);

    // ==========================================================
    // register map (byte offsets) and fields
    localparam logic [7:0] REG_FEATURE = 8'h10;
    localparam logic [7:0] REG_VREF    = 8'h18;
    localparam logic [7:0] REG_CONFIG  = 8'h20;
    localparam logic [7:0] REG_STATUS  = 8'h24;
    localparam logic [7:0] REG_ROW     = 8'h28;

    localparam int FEATURE_ABORT_BIT = 9;
    localparam int VREF_KEEP_BIT     = 7;
    localparam int CFG_CAL_BIT       = 0;
    localparam int CFG_PARITY_BIT    = 1;
    localparam int CFG_GEARDOWN_BIT  = 2;
    localparam int CFG_DLL_ON_BIT    = 3;
    localparam int STAT_NOP_ERR_BIT  = 8;

    localparam logic [31:0] FEATURE_RESET = 32'h0000_0000;
    localparam logic [31:0] VREF_RESET    = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET  = 32'h0000_0008;

    // ==========================================================
    // types
    typedef enum logic [0:0] {st_active, st_self_refresh} sr_state_t;

    typedef struct packed {
        logic ck;
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic activate_low;
        logic termination_control;
    } dram_pins_t;

endpackage

// ### hdl/self_refresh_seq.sv
// Purpose: device-side self refresh entry, residency and exit sequencing
// Assumes: dram pins are asynchronous and sampled by ref_clk_i through two flops
// Notes:   ready flags tell when each command group may follow an exit
//
// Contract
// [R1] entry decoded when cs, ras, cas, cke low and we, activate high
// [R2] controller enters only from idle with all timings met
// [R3] controller holds clock enable low while self refresh continues
// [R4] termination forced off in self refresh, restored on exit
// [R5] loop disabled on entry when enabled, re-enabled with reset on exit
// [R6] in self refresh only clock enable and reset are observed; the code also decodes deselect or no-operation for exit
// [R7] reference kept on allows writes after exit_delay, else after locked delay
// [R8] at least one internal refresh starts right after entry
// [R9] controller keeps residency at least min_residency
// [R10] controller stops clock only after delay, restarts stable before exit
// [R11] exit is clock enable high with deselect on the command bus
// [R12] basic commands wait exit_delay after exit
// [R13] calibration and limited mode writes may follow exit_delay_fast
// [R14] reads and writes wait exit_delay_locked
// [R15] controller holds clock enable high for the locked delay
// [R16] controller waits exit_delay and refreshes before re-entry
// [R17] controller presents deselect during exit_delay
// [R18] controller holds termination control off during locked delay
// [R19] exit_delay is refresh cycle time plus margin
// [R20] abort bit cancels refresh without counting; then exit_delay_abort applies
// [R21] controller issues an extra refresh before re-entry
// [R22] command latency delay is added to every exit wait
// [R23] no-operation exit allowed only with parity, latency, gear-down off
// [R24] only no-operation commands within the no-operation exit window
// [R25] internal timer refreshes periodically, counting rows on completion
`timescale 1ns/1ps

module self_refresh_seq
    import self_refresh_pkg::*;
#(
    parameter int ROW_W         = 16,
    parameter int LOCKED_CYCLES = EXIT_LOCKED_CYCLES
)
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire dram_pins_t        pins_i,
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic [31:0]       reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [31:0]       reg_rdata_o,
    output logic                   self_refresh_o,
    output logic                   termination_on_o,
    output logic                   dll_enable_o,
    output logic                   dll_reset_o,
    output logic                   vref_on_o,
    output logic                   refresh_busy_o,
    output logic                   ready_fast_o,
    output logic                   ready_basic_o,
    output logic                   ready_write_o,
    output logic                   ready_locked_o
);

    // ==========================================================
    // pin synchronisers and link clock edge
    dram_pins_t pin_meta;
    dram_pins_t pin_sync;
    logic       ck_prev;
    logic       ck_rise;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
            ck_prev  <= 1'b0;
        end
        else
        begin
            pin_meta <= pins_i;
            pin_sync <= pin_meta;
            ck_prev  <= pin_sync.ck;
        end
    end

    assign ck_rise = pin_sync.ck && !ck_prev;

    function automatic logic is_entry(input dram_pins_t p);
        return !p.cs_n && !p.ras_n && !p.cas_n && !p.cke && p.we_n && p.activate_low;
    endfunction

    function automatic logic is_nop(input dram_pins_t p);
        return !p.cs_n && p.ras_n && p.cas_n && p.we_n && p.activate_low;
    endfunction

    // ==========================================================
    // registers
    logic [31:0]      feature_mode_reg;
    logic [31:0]      vref_ctrl_mode_reg;
    logic [31:0]      config_reg;
    logic             nop_err;
    logic [ROW_W-1:0] row;
    logic             nop_violation;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            feature_mode_reg   <= FEATURE_RESET;
            vref_ctrl_mode_reg <= VREF_RESET;
            config_reg         <= CONFIG_RESET;
        end
        else if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                REG_FEATURE: feature_mode_reg   <= reg_wdata_i;
                REG_VREF:    vref_ctrl_mode_reg <= reg_wdata_i;
                REG_CONFIG:  config_reg         <= reg_wdata_i;
                default:     ;
            endcase
        end
    end

    // sticky error: a new violation wins over a software clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            nop_err <= 1'b0;
        else if (nop_violation)
            nop_err <= 1'b1;
        else if (reg_wr_i && reg_addr_i == REG_STATUS && reg_wdata_i[STAT_NOP_ERR_BIT])
            nop_err <= 1'b0;
    end

    logic [31:0] status_word;
    assign status_word = {23'h0, nop_err, ready_locked_o, ready_write_o, ready_basic_o,
                          ready_fast_o, vref_on_o, dll_enable_o, refresh_busy_o, self_refresh_o};

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= 32'h0;
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                REG_FEATURE: reg_rdata_o <= feature_mode_reg;
                REG_VREF:    reg_rdata_o <= vref_ctrl_mode_reg;
                REG_CONFIG:  reg_rdata_o <= config_reg;
                REG_STATUS:  reg_rdata_o <= status_word;
                REG_ROW:     reg_rdata_o <= 32'(row);
                default:     reg_rdata_o <= 32'h0;
            endcase
        end
        else
            reg_rdata_o <= 32'h0;
    end

    // ==========================================================
    // entry / exit state
    sr_state_t state;
    logic      entry_evt;
    logic      exit_evt;
    logic      nop_allowed;
    logic      abort_at_exit;
    logic      cal_at_exit;

    // [R1] entry decode
    assign entry_evt = ck_rise && state == st_active && is_entry(pin_sync);
    // [R11] [R23] exit on deselect, or no-operation when entry allowed it
    assign exit_evt = ck_rise && state == st_self_refresh && pin_sync.cke &&
                      (pin_sync.cs_n || (nop_allowed && is_nop(pin_sync)));
    assign nop_violation = ck_rise && state == st_self_refresh && pin_sync.cke &&
                           !nop_allowed && is_nop(pin_sync);

    // [R6] in self refresh only clock enable and the exit decode (deselect or no-operation) are observed
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state <= st_active;
        else if (entry_evt)
            state <= st_self_refresh;
        else if (exit_evt)
            state <= st_active;
    end

    // [R23] no-operation exit fixed by the setup at entry
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            nop_allowed <= 1'b0;
        else if (entry_evt)
            nop_allowed <= !config_reg[CFG_PARITY_BIT] && !config_reg[CFG_CAL_BIT] &&
                           !config_reg[CFG_GEARDOWN_BIT];
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            abort_at_exit <= 1'b0;
            cal_at_exit   <= 1'b0;
        end
        else if (exit_evt)
        begin
            abort_at_exit <= feature_mode_reg[FEATURE_ABORT_BIT];
            cal_at_exit   <= config_reg[CFG_CAL_BIT];
        end
    end

    // ==========================================================
    // internal refresh engine, runs without the link clock
    logic [15:0] period_cnt;
    logic [15:0] busy_cnt;
    logic        busy;
    logic        refresh_done;
    logic        abort_cancel;

    assign refresh_done = busy && busy_cnt == 16'd1 && !abort_cancel;
    // [R20] abort cancels the refresh in flight
    assign abort_cancel = exit_evt && feature_mode_reg[FEATURE_ABORT_BIT];

    // [R8] [R25] first refresh on entry, then one each period
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy       <= 1'b0;
            busy_cnt   <= 16'd0;
            period_cnt <= 16'd0;
        end
        else if (abort_cancel)
        begin
            busy     <= 1'b0;
            busy_cnt <= 16'd0;
        end
        else if (entry_evt || (state == st_self_refresh && !busy && period_cnt == 16'd0))
        begin
            busy       <= 1'b1;
            busy_cnt   <= 16'(REFRESH_CYCLES);
            period_cnt <= 16'(PERIOD_CYCLES - 1);
        end
        else
        begin
            if (busy)
                busy_cnt <= busy_cnt - 16'd1;
            if (refresh_done)
                busy <= 1'b0;
            if (period_cnt != 16'd0)
                period_cnt <= period_cnt - 16'd1;
        end
    end

    // [R25] row counter advances only on a completed refresh
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            row <= '0;
        else if (refresh_done)
            row <= row + ROW_W'(1);
    end

    // ==========================================================
    // exit delay tracking
    logic [15:0] elapsed;
    logic        exit_seen;
    logic [15:0] need_basic;
    logic [15:0] need_fast;
    logic [15:0] need_locked;
    logic [15:0] cal_add;

    // [R22] latency delay added to every exit wait
    assign cal_add     = cal_at_exit ? 16'(CAL_CYCLES) : 16'd0;
    // [R19] [R20] basic wait is refresh time plus margin, or the abort figure
    assign need_basic  = (abort_at_exit ? 16'(EXIT_ABORT_CYCLES) : 16'(EXIT_CYCLES)) + cal_add;
    assign need_fast   = 16'(EXIT_FAST_CYCLES) + cal_add;
    assign need_locked = 16'(LOCKED_CYCLES) + cal_add;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            elapsed   <= 16'd0;
            exit_seen <= 1'b0;
        end
        else if (exit_evt)
        begin
            elapsed   <= 16'd0;
            exit_seen <= 1'b1;
        end
        else if (entry_evt)
            exit_seen <= 1'b0;
        else if (exit_seen && elapsed != 16'hFFFF)
            elapsed <= elapsed + 16'd1;
    end

    // [R12] [R13] [R14] [R7] readiness per command group
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ready_fast_o   <= 1'b1;
            ready_basic_o  <= 1'b1;
            ready_write_o  <= 1'b1;
            ready_locked_o <= 1'b1;
        end
        else if (state == st_self_refresh || exit_evt)
        begin
            ready_fast_o   <= 1'b0;
            ready_basic_o  <= 1'b0;
            ready_write_o  <= 1'b0;
            ready_locked_o <= 1'b0;
        end
        else if (exit_seen)
        begin
            ready_fast_o   <= elapsed >= need_fast;
            ready_basic_o  <= elapsed >= need_basic;
            ready_locked_o <= elapsed >= need_locked;
            // kept reference lets writes in at the basic wait
            ready_write_o  <= vref_ctrl_mode_reg[VREF_KEEP_BIT] ? (elapsed >= need_basic)
                                                                : (elapsed >= need_locked);
        end
    end

    // ==========================================================
    // analog controls
    // [R4] termination off in self refresh whatever the pin says
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            termination_on_o <= 1'b0;
        else
            termination_on_o <= state == st_active && pin_sync.termination_control;
    end

    // [R5] loop off on entry, back on with a one cycle reset pulse at exit
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dll_enable_o <= 1'b0;
            dll_reset_o  <= 1'b0;
        end
        else
        begin
            dll_enable_o <= config_reg[CFG_DLL_ON_BIT] && state == st_active && !entry_evt;
            dll_reset_o  <= exit_evt && config_reg[CFG_DLL_ON_BIT];
        end
    end

    // [R7] reference generator may power down in self refresh
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            vref_on_o      <= 1'b1;
            self_refresh_o <= 1'b0;
            refresh_busy_o <= 1'b0;
        end
        else
        begin
            vref_on_o      <= state == st_active || vref_ctrl_mode_reg[VREF_KEEP_BIT];
            self_refresh_o <= state == st_self_refresh;
            refresh_busy_o <= busy;
        end
    end

    // ==========================================================
    // assertions
    property p_entry;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        entry_evt |=> state == st_self_refresh ##1 self_refresh_o;
    endproperty
    a_entry: assert property (p_entry) else $error("entry not taken"); // [R1]

    property p_term_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        state == st_self_refresh |=> !termination_on_o;
    endproperty
    a_term_off: assert property (p_term_off) else $error("termination on in self refresh"); // [R4]

    property p_dll_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        entry_evt |=> !dll_enable_o;
    endproperty
    a_dll_off: assert property (p_dll_off) else $error("loop still on after entry"); // [R5]

    property p_hold_sr;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        state == st_self_refresh && !pin_sync.cke |=> state == st_self_refresh;
    endproperty
    a_hold_sr: assert property (p_hold_sr) else $error("left self refresh without enable"); // [R6]

    property p_first_refresh;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        entry_evt |=> busy ##1 refresh_busy_o;
    endproperty
    a_first_refresh: assert property (p_first_refresh) else $error("no refresh at entry"); // [R8]

    property p_row_step;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        refresh_done |=> row == $past(row) + ROW_W'(1) && !busy;
    endproperty
    a_row_step: assert property (p_row_step) else $error("row not advanced"); // [R25]

    property p_abort;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        abort_cancel |=> !busy && $stable(row);
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not cancel refresh"); // [R20]

    property p_exit;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        exit_evt |=> state == st_active && dll_reset_o == config_reg[CFG_DLL_ON_BIT];
    endproperty
    a_exit: assert property (p_exit) else $error("exit not handled"); // [R11]

    property p_basic_wait;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(ready_basic_o) |-> $past(elapsed) >= need_basic;
    endproperty
    a_basic_wait: assert property (p_basic_wait) else $error("basic ready too early"); // [R19]

    property p_write_gate;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ready_write_o && !vref_ctrl_mode_reg[VREF_KEEP_BIT] && exit_seen |-> $past(elapsed) >= need_locked;
    endproperty
    a_write_gate: assert property (p_write_gate) else $error("write ready before locked delay"); // [R7]

endmodule

// ### bench/dram_ctrl_model.sv
// Purpose: behavioural memory controller driving the sequencer's pins
// Assumes: each command is set up with the link clock low and held a full 900 ns frame
// Notes:   the link clock stands still between frames, like a stopped clock
`timescale 1ns/1ps

module dram_ctrl_model
    import self_refresh_pkg::*;
(
    input  wire logic  ref_clk_i,
    output dram_pins_t pins_o
);
    // ==========================================================
    // command codes {cke, cs_n, ras_n, cas_n, we_n, activate_low}
    localparam logic [5:0] DESEL_HI = 6'h3F;
    localparam logic [5:0] DESEL_LO = 6'h1F;
    localparam logic [5:0] ENTRY    = 6'h03;
    localparam logic [5:0] REFRESH  = 6'h23;
    localparam logic [5:0] NOP_HI   = 6'h2F;

    initial pins_o = dram_pins_t'(8'h7E);

    // ==========================================================
    // frames
    // hold=0 leaves the clock standing high, so the bench can time the answer itself
    task automatic cmd(input logic [5:0] c, input logic hold);
        @(posedge ref_clk_i);
        pins_o.ck <= 1'b0;
        {pins_o.cke, pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n, pins_o.activate_low} <= c;
        repeat (4) @(posedge ref_clk_i);
        pins_o.ck <= 1'b1;
        if (hold)
            repeat (4) @(posedge ref_clk_i);
    endtask

    task automatic set_term(input logic v);
        @(posedge ref_clk_i);
        pins_o.termination_control <= v;
    endtask

    task automatic enter();
        cmd(DESEL_HI, 1'b1);
        cmd(REFRESH, 1'b1);
        cmd(DESEL_HI, 1'b1);
        cmd(ENTRY, 1'b1);
        // enable held low for the residency
        cmd(DESEL_LO, 1'b1);
        cmd(DESEL_LO, 1'b1);
    endtask

    task automatic leave(input logic no_operation);
        set_term(1'b0);
        cmd(DESEL_LO, 1'b1);
        cmd(no_operation ? NOP_HI : DESEL_HI, 1'b0);
    endtask
endmodule

// ### bench/tb_top.sv
// Purpose: self-checking bench for the self refresh sequencer
// Assumes: locked delay shortened to 20 cycles; controller model drives the pins
// Notes:   ready timings are counted from the cycle the status output drops
`timescale 1ns/1ps

module tb_top;
    import self_refresh_pkg::*;

    localparam int LOCK = 20;

    logic        ref_clk;
    logic        rst_n;
    dram_pins_t  pins;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        sr;
    logic        term_on;
    logic        dll_en;
    logic        dll_rst;
    logic        vref_on;
    logic        busy;
    wire [3:0]   rdy;
    logic [31:0] d;
    int          fails    = 0;
    int          checked  = 0;
    int          resets   = 0;
    int          busy_cnt = 0;

    self_refresh_seq #(.ROW_W(16), .LOCKED_CYCLES(LOCK)) uut (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .pins_i(pins), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .self_refresh_o(sr), .termination_on_o(term_on), .dll_enable_o(dll_en),
        .dll_reset_o(dll_rst), .vref_on_o(vref_on), .refresh_busy_o(busy),
        .ready_fast_o(rdy[0]), .ready_basic_o(rdy[1]), .ready_write_o(rdy[2]), .ready_locked_o(rdy[3])
    );

    dram_ctrl_model ctrl (.ref_clk_i(ref_clk), .pins_o(pins));

    always #50 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        if (dll_rst === 1'b1)
            resets <= resets + 1;
        if (busy === 1'b1)
            busy_cnt <= busy_cnt + 1;
    end

    // ==========================================================
    // helpers
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic wait_sr(input logic v);
        for (int i = 0; i < 400; i++)
        begin
            @(posedge ref_clk);
            #1;
            if (sr === v)
                return;
        end
        chk("sr_wait", v, ~v);
        final_report();
    endtask

    // ==========================================================
    // scenarios
    task automatic enter_chk(input logic kp);
        logic [31:0] row0;
        int          b0;
        ctrl.set_term(1'b1);
        tick(4);
        chk("term_active", 1, term_on);
        rd(REG_ROW, row0);
        b0 = busy_cnt;
        ctrl.enter();
        wait_sr(1'b1);
        chk("refresh_started", 1, busy_cnt > b0);
        chk("dll_en_sr", 0, dll_en);
        chk("term_sr", 0, term_on);
        chk("vref_sr", kp, vref_on);
        chk("ready_sr", 0, rdy);
        ctrl.cmd(6'h03, 1'b1);
        ctrl.cmd(6'h10, 1'b1);
        chk("sr_ignores", 1, sr);
        tick(100);
        rd(REG_ROW, d);
        chk("row_advanced", 1, d > row0);
    endtask

    task automatic sr_cycle(input logic ab, input logic kp, input logic cl);
        int first [4];
        int exp [4];
        int c;
        int r0;
        c = cl ? CAL_CYCLES : 0;
        exp = '{EXIT_FAST_CYCLES + c, (ab ? EXIT_ABORT_CYCLES : EXIT_CYCLES) + c,
                (kp ? EXIT_CYCLES : LOCK) + c, LOCK + c};
        first = '{-1, -1, -1, -1};
        wr(REG_FEATURE, ab ? (32'h1 << FEATURE_ABORT_BIT) : 32'h0);
        wr(REG_VREF, kp ? (32'h1 << VREF_KEEP_BIT) : 32'h0);
        wr(REG_CONFIG, CONFIG_RESET | (cl ? (32'h1 << CFG_CAL_BIT) : 32'h0));
        enter_chk(kp);
        r0 = resets;
        ctrl.leave(1'b0);
        wait_sr(1'b0);
        for (int k = 0; k < 150; k++)
        begin
            for (int j = 0; j < 4; j++)
                if (rdy[j] === 1'b1 && first[j] < 0)
                    first[j] = k;
            @(posedge ref_clk);
            #1;
        end
        chk("ready_fast", exp[0], first[0]);
        chk("ready_basic", exp[1], first[1]);
        chk("ready_write", exp[2], first[2]);
        chk("ready_locked", exp[3], first[3]);
        chk("loop_reset", r0 + 1, resets);
        chk("dll_en_back", 1, dll_en);
        ctrl.set_term(1'b1);
        tick(4);
        chk("term_back", 1, term_on);
    endtask

    initial
    begin
        ref_clk   = 1'b0;
        rst_n     = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        tick(2);
        chk("ready_rst", 32'hF, rdy);
        chk("vref_rst", 1, vref_on);
        chk("dll_en_rst", 1, dll_en);
        chk("sr_rst", 0, sr);
        rd(REG_CONFIG, d);
        chk("config_rst", CONFIG_RESET, d);
        rd(REG_FEATURE, d);
        chk("feature_rst", FEATURE_RESET, d);
        rd(REG_VREF, d);
        chk("vref_reg_rst", VREF_RESET, d);
        wr(8'h04, 32'hFFFF_FFFF);
        rd(8'h04, d);
        chk("unmapped", 32'h0, d);
        sr_cycle(1'b0, 1'b0, 1'b0);
        sr_cycle(1'b1, 1'b0, 1'b0);
        sr_cycle(1'b0, 1'b1, 1'b1);
        // no-operation exit refused for each of cal, parity and gear-down
        for (int b = 0; b < 3; b++)
        begin
            wr(REG_CONFIG, CONFIG_RESET | (32'h1 << b));
            enter_chk(1'b1);
            ctrl.leave(1'b1);
            tick(12);
            chk("nop_refused", 1, sr);
            rd(REG_STATUS, d);
            chk("nop_err", 32'h1 << STAT_NOP_ERR_BIT, d & (32'h1 << STAT_NOP_ERR_BIT));
            ctrl.leave(1'b0);
            wait_sr(1'b0);
            tick(60);
            wr(REG_STATUS, 32'h1 << STAT_NOP_ERR_BIT);
            rd(REG_STATUS, d);
            chk("nop_err_clr", 32'h0, d & (32'h1 << STAT_NOP_ERR_BIT));
        end
        wr(REG_CONFIG, CONFIG_RESET);
        enter_chk(1'b1);
        ctrl.leave(1'b1);
        wait_sr(1'b0);
        tick(60);
        final_report();
    end
endmodule
